//--- logic/smb_consts.vh
/*
 Constants for the two-wire serial controller: the address of its
 control and status register, the bit positions inside it, its reset
 value, the bus-free tick count and the phase codes of the START and
 STOP sequencers.
 Assumes it is included by bare name at the top of each design file.
*/
// How it works
// - Both lines high over ten ticks: free.
// - Pending START issued right after free timeout.
// - Interrupt for every byte and address moved.
// - Transmitter interrupts after ACK without hardware ack.
// - Receiver interrupts before ACK without hardware ack.
// - Hardware ack: interrupts always after ACK cycle.
// - Interrupt on own START and slave STOP.
// - Enable gates all events; disabled means inactive.
// - Inhibited slave monitors, NACKs, never interrupts.
// - Inhibit latched at next START only.
// - SCL toggled only as master, only stretched as slave; SDA follows SCL.
// - Bits seven and six show master, transmitter.
// - Start flag only reads back the request; writing one requests.
// - Stop flag sends STOP after ACK, self-clears.
// - Stop flag shows slave STOP or pending STOP.
// - Bit two shows arbitration lost.
// - Hardware sets interrupt flag; software clears it.
// - Pending START or byte interrupt holds SCL low, stalls bus.
// - Writing zero resumes; writing one forces interrupt.
// - Hardware ack enable selects automatic acknowledge.
`ifndef SMB_CONSTS_VH
`define SMB_CONSTS_VH
`define SMB_CS_ADDR    8'hC0
`define SMB_CS_RST     8'h00
`define SMB_B_MST      7
`define SMB_B_TXM      6
`define SMB_B_STA      5
`define SMB_B_STO      4
`define SMB_B_ARQ      3
`define SMB_B_ARB      2
`define SMB_B_ACK      1
`define SMB_B_SI       0
`define SMB_FREE_TICKS 4'hA
`define SMB_LAST_BIT   3'h7
`define SMB_PH0        3'h0
`define SMB_PH1        3'h1
`define SMB_PH2        3'h2
`endif

//--- logic/smb_linemon.v
/*
 Line monitor: synchronises SCL and SDA, reports SCL edges, START and
 STOP conditions, and the bus-free timeout.
 Assumes the pins are asynchronous to clk and that tick is a one-cycle
 pulse from a timer on clk.
*/
`include "smb_consts.vh"
module smb_linemon (
   input  wire clk,
   input  wire rst_n,
   input  wire scl_i,
   input  wire sda_i,
   input  wire tick,
   input  wire free_en,
   output wire scl_s,
   output wire sda_s,
   output wire start_det,
   output wire stop_det,
   output wire scl_rise,
   output wire scl_fall,
   output reg  free_pulse
);
   reg       scl_meta_reg;
   reg       scl_sync_reg;
   reg       scl_prev_reg;
   reg       sda_meta_reg;
   reg       sda_sync_reg;
   reg       sda_prev_reg;
   reg [3:0] free_cnt_reg;

   // Two flip-flops per pin, then one more stage for edge detection.
   always @(posedge clk) begin
      if (!rst_n) begin
         scl_meta_reg <= 1'h1;
         scl_sync_reg <= 1'h1;
         scl_prev_reg <= 1'h1;
         sda_meta_reg <= 1'h1;
         sda_sync_reg <= 1'h1;
         sda_prev_reg <= 1'h1;
      end else begin
         scl_meta_reg <= scl_i;
         scl_sync_reg <= scl_meta_reg;
         scl_prev_reg <= scl_sync_reg;
         sda_meta_reg <= sda_i;
         sda_sync_reg <= sda_meta_reg;
         sda_prev_reg <= sda_sync_reg;
      end
   end

   assign scl_s     = scl_sync_reg;
   assign sda_s     = sda_sync_reg;
   assign scl_rise  = scl_sync_reg & ~scl_prev_reg;
   assign scl_fall  = ~scl_sync_reg & scl_prev_reg;
   // SDA moving while SCL stays high marks START or STOP.
   assign start_det = scl_sync_reg & scl_prev_reg & sda_prev_reg &
                      ~sda_sync_reg;
   assign stop_det  = scl_sync_reg & scl_prev_reg & ~sda_prev_reg &
                      sda_sync_reg;

   // Without ticks the counter never moves, so a slave-only user still
   // needs the timer running.
   always @(posedge clk) begin
      if (!rst_n) begin
         free_cnt_reg <= 4'h0;
         free_pulse   <= 1'h0;
      end else begin
         free_pulse <= 1'h0;
         if (!free_en || !scl_sync_reg || !sda_sync_reg) begin
            free_cnt_reg <= 4'h0;
         end else if (tick && free_cnt_reg <= `SMB_FREE_TICKS) begin
            free_cnt_reg <= free_cnt_reg + 4'h1;
            // The eleventh tick means more than ten periods.
            if (free_cnt_reg == `SMB_FREE_TICKS) begin
               free_pulse <= 1'h1;
            end
         end
      end
   end
endmodule

//--- logic/smb_ctrl.v
/*
 Byte-oriented two-wire controller, master and slave, with its control
 and status register on the special-function register port.
 Assumes BIT_CLK_TICK is a one-cycle pulse on SYS_CLK from a timer, the
 configuration inputs and TX_DATA, SLAVE_ADDR come from logic on
 SYS_CLK, and the pins are open-drain and asynchronous.
*/
`include "smb_consts.vh"
module smb_ctrl (
   input  wire       SYS_CLK,
   input  wire       RESETN,
   input  wire [7:0] SFR_ADDR,
   input  wire       SFR_WR,
   input  wire [7:0] SFR_WDATA,
   output wire [7:0] SFR_RDATA,
   input  wire       INTERFACE_ENABLE,
   input  wire       SLAVE_INHIBIT,
   input  wire       HW_ACK_ENABLE,
   input  wire       BUS_FREE_TIMEOUT_ENABLE,
   input  wire       BIT_CLK_TICK,
   input  wire [6:0] SLAVE_ADDR,
   input  wire [7:0] TX_DATA,
   output wire [7:0] RX_DATA,
   output wire       INTERRUPT_PENDING,
   input  wire       SCL_I,
   output wire       SCL_O,
   output wire       SCL_OEN,
   input  wire       SDA_I,
   output wire       SDA_O,
   output wire       SDA_OEN
);
   localparam S_IDLE = 3'h0;
   localparam S_MSTA = 3'h1;
   localparam S_WAIT = 3'h2;
   localparam S_BITS = 3'h3;
   localparam S_ACK  = 3'h4;
   localparam S_MSTO = 3'h5;
   localparam S_SKIP = 3'h6;

   reg [2:0] state_reg;
   reg [2:0] cnt_reg;
   reg [7:0] shift_reg;
   reg [7:0] rx_data_reg;
   reg [7:0] rdata_reg;
   reg       master_reg;
   reg       txm_reg;
   reg       sta_reg;
   reg       sto_reg;
   reg       arq_reg;
   reg       arb_reg;
   reg       ack_reg;
   reg       si_reg;
   reg       scl_low_reg;
   reg       sda_low_reg;
   reg       addr_ph_reg;
   reg       rw_reg;
   reg       pend_ack_reg;
   reg       sw_ack_reg;
   reg       inh_act_reg;
   reg       addressed_reg;
   reg       busy_reg;
   reg       bit_hi_reg;

   wire       scl_s;
   wire       sda_s;
   wire       start_det;
   wire       stop_det;
   wire       scl_rise;
   wire       scl_fall;
   wire       free_pulse;
   wire       cs_wr;
   wire       si_clr;
   wire       tx_after;
   wire [7:0] status_w;

   // Whether SDA must be pulled low for the bit in d[7] of each byte; only when transmitting.
   function first_low;
      input       tx;
      input [7:0] d;
      begin
         first_low = tx & ~d[7];
      end
   endfunction

   smb_linemon u_mon (
      .clk       (SYS_CLK),
      .rst_n     (RESETN),
      .scl_i     (SCL_I),
      .sda_i     (SDA_I),
      .tick      (BIT_CLK_TICK),
      .free_en   (BUS_FREE_TIMEOUT_ENABLE),
      .scl_s     (scl_s),
      .sda_s     (sda_s),
      .start_det (start_det),
      .stop_det  (stop_det),
      .scl_rise  (scl_rise),
      .scl_fall  (scl_fall),
      .free_pulse(free_pulse)
   );

   assign cs_wr  = SFR_WR && (SFR_ADDR == `SMB_CS_ADDR);
   assign si_clr = cs_wr && !SFR_WDATA[`SMB_B_SI] && si_reg;
   // Direction of the byte after the address byte.
   assign tx_after = addr_ph_reg ? (master_reg ? ~rw_reg : rw_reg)
                                 : txm_reg;
   // Bit order follows the register layout, bit 7 first.
   assign status_w = {master_reg, txm_reg, sta_reg, sto_reg,
                      arq_reg, arb_reg, ack_reg, si_reg};

   // Open drain: the output value is always low, the enable does the work.
   assign SCL_O             = 1'h0;
   assign SDA_O             = 1'h0;
   assign SCL_OEN           = ~scl_low_reg;
   assign SDA_OEN           = ~sda_low_reg;
   assign SFR_RDATA         = rdata_reg;
   assign RX_DATA           = rx_data_reg;
   assign INTERRUPT_PENDING = si_reg;

   // Read data is registered, so a read shows one cycle after the address.
   always @(posedge SYS_CLK) begin
      if (!RESETN) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= (SFR_ADDR == `SMB_CS_ADDR) ? status_w : 8'h00;
      end
   end

   // Bus occupancy; the free timeout ends it when no STOP was seen.
   always @(posedge SYS_CLK) begin
      if (!RESETN) begin
         busy_reg <= 1'h0;
      end else if (start_det) begin
         busy_reg <= 1'h1;
      end else if (stop_det || free_pulse) begin
         busy_reg <= 1'h0;
      end
   end

   // Main sequencer. Software writes come first in the block so that a
   // hardware set later in the same cycle wins over a software clear.
   always @(posedge SYS_CLK) begin
      if (!RESETN) begin
         {master_reg, txm_reg, sta_reg, sto_reg,
          arq_reg, arb_reg, ack_reg, si_reg} <= `SMB_CS_RST;
         state_reg     <= S_IDLE;
         cnt_reg       <= `SMB_PH0;
         shift_reg     <= 8'h00;
         rx_data_reg   <= 8'h00;
         scl_low_reg   <= 1'h0;
         sda_low_reg   <= 1'h0;
         addr_ph_reg   <= 1'h0;
         rw_reg        <= 1'h0;
         pend_ack_reg  <= 1'h0;
         sw_ack_reg    <= 1'h0;
         inh_act_reg   <= 1'h0;
         addressed_reg <= 1'h0;
         bit_hi_reg    <= 1'h0;
      end else begin
         if (cs_wr) begin
            sta_reg <= SFR_WDATA[`SMB_B_STA];
            sto_reg <= SFR_WDATA[`SMB_B_STO];
            ack_reg <= SFR_WDATA[`SMB_B_ACK];
            si_reg  <= SFR_WDATA[`SMB_B_SI];
         end
         if (!INTERFACE_ENABLE) begin
            // Disabled: lines released, no events at all.
            state_reg     <= S_IDLE;
            master_reg    <= 1'h0;
            txm_reg       <= 1'h0;
            arq_reg       <= 1'h0;
            scl_low_reg   <= 1'h0;
            sda_low_reg   <= 1'h0;
            addressed_reg <= 1'h0;
            pend_ack_reg  <= 1'h0;
            sw_ack_reg    <= 1'h0;
         end else if (!master_reg && (stop_det || free_pulse)) begin
            // A STOP, or a bus gone free without one, ends any slave
            // transfer; only a real STOP is reported.
            if (stop_det && addressed_reg && !inh_act_reg) begin
               sto_reg <= 1'h1;
               si_reg  <= 1'h1;
            end
            state_reg     <= S_IDLE;
            txm_reg       <= 1'h0;
            arq_reg       <= 1'h0;
            scl_low_reg   <= 1'h0;
            sda_low_reg   <= 1'h0;
            addressed_reg <= 1'h0;
            pend_ack_reg  <= 1'h0;
            sw_ack_reg    <= 1'h0;
         end else if (!master_reg && start_det) begin
            // Another master starts: receive the address byte.
            inh_act_reg   <= SLAVE_INHIBIT;
            bit_hi_reg    <= 1'h0;
            state_reg     <= S_BITS;
            cnt_reg       <= `SMB_PH0;
            addr_ph_reg   <= 1'h1;
            txm_reg       <= 1'h0;
            addressed_reg <= 1'h0;
            scl_low_reg   <= 1'h0;
            sda_low_reg   <= 1'h0;
            pend_ack_reg  <= 1'h0;
            sw_ack_reg    <= 1'h0;
         end else begin
            // Only a master toggles SCL; slaves merely stretch it.
            if (master_reg && BIT_CLK_TICK &&
                (state_reg == S_BITS || state_reg == S_ACK)) begin
               if (scl_low_reg) begin
                  scl_low_reg <= 1'h0;
               end else if (scl_s) begin
                  scl_low_reg <= 1'h1;
               end
            end
            case (state_reg)
               S_IDLE: begin
                  // Free bus and a pending request: start at once.
                  if (sta_reg && !busy_reg) begin
                     master_reg  <= 1'h1;
                     arb_reg     <= 1'h0;
                     txm_reg     <= 1'h1;
                     addr_ph_reg <= 1'h1;
                     cnt_reg     <= `SMB_PH0;
                     state_reg   <= S_MSTA;
                  end
               end
               S_MSTA: begin
                  // Release both, pull SDA with SCL high, then pull SCL.
                  if (cnt_reg == `SMB_PH0) begin
                     if (BIT_CLK_TICK) begin
                        sda_low_reg <= 1'h0;
                        scl_low_reg <= 1'h0;
                        cnt_reg     <= `SMB_PH1;
                     end
                  end else if (cnt_reg == `SMB_PH1) begin
                     if (BIT_CLK_TICK && scl_s && sda_s) begin
                        sda_low_reg <= 1'h1;
                        cnt_reg     <= `SMB_PH2;
                     end
                  end else if (BIT_CLK_TICK) begin
                     scl_low_reg <= 1'h1;
                     si_reg      <= 1'h1;
                     state_reg   <= S_WAIT;
                  end
               end
               S_WAIT: begin
                  scl_low_reg <= 1'h1;
                  if (si_clr) begin
                     if (master_reg && SFR_WDATA[`SMB_B_STO]) begin
                        state_reg <= S_MSTO;
                        cnt_reg   <= `SMB_PH0;
                     end else if (master_reg && SFR_WDATA[`SMB_B_STA]) begin
                        state_reg <= S_MSTA; // Repeated START.
                        cnt_reg   <= `SMB_PH0;
                     end else if (pend_ack_reg) begin
                        // Software has chosen the ACK value.
                        sda_low_reg  <= SFR_WDATA[`SMB_B_ACK];
                        arq_reg      <= 1'h0;
                        pend_ack_reg <= 1'h0;
                        sw_ack_reg   <= 1'h1;
                        scl_low_reg  <= 1'h0;
                        state_reg    <= S_ACK;
                     end else begin
                        if (master_reg && addr_ph_reg) begin
                           rw_reg <= TX_DATA[0];
                        end
                        shift_reg   <= TX_DATA;
                        sda_low_reg <= first_low(txm_reg, TX_DATA);
                        cnt_reg     <= `SMB_PH0;
                        scl_low_reg <= 1'h0;
                        state_reg   <= S_BITS;
                     end
                  end
               end
               S_BITS: begin
                  if (scl_rise) begin
                     // Data is sampled on the rising SCL edge.
                     shift_reg <= {shift_reg[6:0], sda_s};
                     bit_hi_reg <= 1'h1;
                     if (master_reg && txm_reg && !sda_low_reg && !sda_s)
                     begin
                        // Someone else drives low: back off.
                        arb_reg     <= 1'h1;
                        master_reg  <= 1'h0;
                        txm_reg     <= 1'h0;
                        sda_low_reg <= 1'h0;
                        scl_low_reg <= 1'h0;
                        si_reg      <= 1'h1;
                        state_reg   <= S_SKIP;
                     end
                  end else if (scl_fall && bit_hi_reg) begin
                     // The fall closing a START has no rise before it.
                     bit_hi_reg <= 1'h0;
                     if (cnt_reg != `SMB_LAST_BIT) begin
                        cnt_reg     <= cnt_reg + 3'h1;
                        sda_low_reg <= first_low(txm_reg, shift_reg);
                     end else if (txm_reg) begin
                        sda_low_reg <= 1'h0; // Free SDA for the ACK.
                        state_reg   <= S_ACK;
                     end else begin
                        rx_data_reg <= shift_reg;
                        if (addr_ph_reg && !master_reg) begin
                           rw_reg <= shift_reg[0];
                           if (inh_act_reg) begin
                              state_reg <= S_SKIP;
                           end else if (HW_ACK_ENABLE) begin
                              // Automatic address recognition.
                              if (shift_reg[7:1] == SLAVE_ADDR) begin
                                 addressed_reg <= 1'h1;
                                 sda_low_reg   <= 1'h1;
                                 state_reg     <= S_ACK;
                              end else begin
                                 state_reg <= S_SKIP;
                              end
                           end else begin
                              addressed_reg <= 1'h1;
                              arq_reg       <= 1'h1;
                              pend_ack_reg  <= 1'h1;
                              si_reg        <= 1'h1;
                              scl_low_reg   <= 1'h1;
                              state_reg     <= S_WAIT;
                           end
                        end else if (HW_ACK_ENABLE) begin
                           sda_low_reg <= ack_reg;
                           state_reg   <= S_ACK;
                        end else begin
                           arq_reg      <= 1'h1;
                           pend_ack_reg <= 1'h1;
                           si_reg       <= 1'h1;
                           scl_low_reg  <= 1'h1;
                           state_reg    <= S_WAIT;
                        end
                     end
                  end
               end
               S_ACK: begin
                  if (scl_rise && txm_reg) begin
                     ack_reg <= ~sda_s; // Received ACK for software.
                  end else if (scl_fall) begin
                     addr_ph_reg <= 1'h0;
                     txm_reg     <= tx_after;
                     sw_ack_reg  <= 1'h0;
                     sda_low_reg <= 1'h0;
                     if (master_reg && sto_reg) begin
                        scl_low_reg <= 1'h1;
                        cnt_reg     <= `SMB_PH0;
                        state_reg   <= S_MSTO;
                     end else if (sw_ack_reg && !master_reg &&
                                  addr_ph_reg && !ack_reg) begin
                        addressed_reg <= 1'h0;
                        state_reg     <= S_SKIP;
                     end else if (sw_ack_reg) begin
                        // Interrupt already given before this ACK.
                        shift_reg   <= TX_DATA;
                        sda_low_reg <= first_low(tx_after, TX_DATA);
                        cnt_reg     <= `SMB_PH0;
                        state_reg   <= S_BITS;
                     end else begin
                        si_reg      <= 1'h1;
                        scl_low_reg <= 1'h1;
                        state_reg   <= S_WAIT;
                     end
                  end
               end
               S_MSTO: begin
                  // SDA low, release SCL, then release SDA while high.
                  if (cnt_reg == `SMB_PH0) begin
                     sda_low_reg <= 1'h1;
                     if (BIT_CLK_TICK) begin
                        scl_low_reg <= 1'h0;
                        cnt_reg     <= `SMB_PH1;
                     end
                  end else if (BIT_CLK_TICK && scl_s) begin
                     sda_low_reg <= 1'h0;
                     sto_reg     <= 1'h0;
                     master_reg  <= 1'h0;
                     txm_reg     <= 1'h0;
                     state_reg   <= S_IDLE;
                  end
               end
               S_SKIP: begin
                  // Not involved: watch lines until START or STOP.
                  scl_low_reg <= 1'h0;
                  sda_low_reg <= 1'h0;
               end
               default: begin
                  state_reg <= S_IDLE;
               end
            endcase
         end
      end
   end
endmodule

//--- tb/smb_ctrl_monitor.sv
/*
 Checker for the two-wire controller, watching its top-level ports.
 Assumes the status register sits at the design's register address.
*/
`include "smb_consts.vh"
module smb_ctrl_monitor (
   input wire logic       SYS_CLK,
   input wire logic       RESETN,
   input wire logic [7:0] SFR_ADDR,
   input wire logic       SFR_WR,
   input wire logic [7:0] SFR_WDATA,
   input wire logic [7:0] SFR_RDATA,
   input wire logic       INTERFACE_ENABLE,
   input wire logic       INTERRUPT_PENDING,
   input wire logic       SCL_OEN,
   input wire logic       SDA_OEN
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESETN);
   // Register selection and write decode.
   wire sel_cs = SFR_ADDR == `SMB_CS_ADDR;
   wire wr_cs  = SFR_WR && sel_cs;
   // A pending interrupt that keeps the clock line low.
   sequence si_wait_s;
      INTERRUPT_PENDING && !SCL_OEN ##1 INTERRUPT_PENDING;
   endsequence
   // A start request followed by a read of the register.
   sequence sta_write_s;
      wr_cs && SFR_WDATA[5] && INTERFACE_ENABLE ##1 sel_cs;
   endsequence
   si_hold_a: assert property (
      INTERRUPT_PENDING && INTERFACE_ENABLE && !(wr_cs && !SFR_WDATA[0])
      |=> INTERRUPT_PENDING) else $error("flag dropped");
   si_force_a: assert property (
      wr_cs && SFR_WDATA[0] |=> INTERRUPT_PENDING) else $error("no force");
   scl_stall_a: assert property (
      si_wait_s |-> !SCL_OEN) else $error("clock freed");
   sda_stall_a: assert property (
      si_wait_s |-> $stable(SDA_OEN)) else $error("data moved");
   rdata_zero_a: assert property (
      !sel_cs |=> SFR_RDATA == 8'h00) else $error("stray read");
   rdata_si_a: assert property (
      sel_cs |=> SFR_RDATA[0] == $past(INTERRUPT_PENDING))
      else $error("flag read");
   sta_read_a: assert property (
      sta_write_s |=> SFR_RDATA[5]) else $error("start lost");
   off_idle_a: assert property (
      !INTERFACE_ENABLE [*3] |-> SCL_OEN && SDA_OEN) else $error("active");
endmodule

bind smb_ctrl smb_ctrl_monitor u_chk (.SYS_CLK(SYS_CLK), .RESETN(RESETN),
   .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA),
   .SFR_RDATA(SFR_RDATA), .INTERFACE_ENABLE(INTERFACE_ENABLE),
   .INTERRUPT_PENDING(INTERRUPT_PENDING), .SCL_OEN(SCL_OEN),
   .SDA_OEN(SDA_OEN));

//--- tb/smb_peer.sv
/*
 Behavioural slave on the far side: acknowledges its address and the
 bytes written to it, and keeps the last byte.
 Assumes open-drain lines with pull-ups; a released line reads 1.
*/
module smb_peer #(
   parameter logic [6:0] ADDR = 7'h2A
) (
   input  wire logic       scl,
   input  wire logic       sda,
   output logic            sda_n,
   output logic [7:0]      last_byte
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] cnt = 4'h0;
   logic [7:0] sh = 8'h00;
   logic       sel = 0;
   logic       first = 0;
   initial sda_n = 1;
   initial last_byte = 8'h00;
   // START and STOP restart framing, and both deselect us.
   always @(sda) if (scl === 1'b1) begin
      cnt = 4'h0;
      first = !sda;
      sel = 0;
   end
   // Bits are taken MSB first on the rising clock.
   always @(posedge scl) if (cnt < 4'h8) begin
      sh = {sh[6:0], sda};
      cnt++;
   end
   // The acknowledge is driven from one falling clock edge to the next.
   always @(negedge scl) begin
      if (cnt == 4'h8) begin
         if (first) sel = sh[7:1] == ADDR;
         else if (sel) last_byte = sh;
         first = 0;
         sda_n = !sel;
         cnt = 4'h9;
      end else if (cnt == 4'h9) begin
         sda_n = 1;
         cnt = 4'h0;
      end
   end
endmodule

//--- tb/smb_ctrl_tb.sv
/*
 Bench: registers, forced interrupt, bus-free START, a master write.
 Assumes the design, checker and peer model are compiled first.
*/
module smb_ctrl_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic       SYS_CLK = 0, RESETN = 0, SFR_WR = 0, BIT_CLK_TICK = 0;
   logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, TX_DATA = 8'h00;
   logic       en = 1, slave_inhibit = 0, b_scl = 1, b_sda = 1;
   logic [4:0] tdiv = 5'h00;
   int         err_count = 0, compares = 0, cyc = 0;
   wire  [7:0] SFR_RDATA, RX_DATA, pbyte;
   wire        SCL_O, SCL_OEN, SDA_O, SDA_OEN, INTERRUPT_PENDING, p_sda;
   // Wired-AND lines with pull-ups.
   wire scl = (SCL_OEN | SCL_O) & b_scl;
   wire sda = (SDA_OEN | SDA_O) & b_sda & p_sda;
   smb_ctrl dut (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .SFR_ADDR(SFR_ADDR),
      .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
      .INTERFACE_ENABLE(en), .SLAVE_INHIBIT(slave_inhibit), .HW_ACK_ENABLE(1'b0),
      .BUS_FREE_TIMEOUT_ENABLE(1'b1), .BIT_CLK_TICK(BIT_CLK_TICK),
      .SLAVE_ADDR(7'h11), .TX_DATA(TX_DATA), .RX_DATA(RX_DATA),
      .INTERRUPT_PENDING(INTERRUPT_PENDING), .SCL_I(scl), .SCL_O(SCL_O),
      .SCL_OEN(SCL_OEN), .SDA_I(sda), .SDA_O(SDA_O), .SDA_OEN(SDA_OEN));
   smb_peer #(.ADDR(7'h2A)) peer (.scl(scl), .sda(sda), .sda_n(p_sda),
      .last_byte(pbyte));
   always #2.5 SYS_CLK = ~SYS_CLK;
   // The bit clock ticks every 160 ns even for idle use.
   always @(negedge SYS_CLK) begin
      tdiv <= tdiv + 5'h01;
      BIT_CLK_TICK <= tdiv == 5'h1F;
   end
   task tally_and_finish();
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // The run needs a few thousand cycles; a hang ends it.
   always @(posedge SYS_CLK) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         tally_and_finish();
      end
   end
   task chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge SYS_CLK);
      SFR_ADDR = a;
      SFR_WDATA = d;
      SFR_WR = 1;
      @(negedge SYS_CLK);
      SFR_WR = 0;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge SYS_CLK);
      SFR_ADDR = a;
      @(negedge SYS_CLK);
      d = SFR_RDATA;
   endtask
   task wait_si();
      for (int c = 0; c < 3000 && INTERRUPT_PENDING !== 1'b1; c++)
         @(negedge SYS_CLK);
      chk({7'h00, INTERRUPT_PENDING}, 8'h01);
   endtask
   // Reset value, read-only bits, an unmapped address, forced flag.
   task t_regs();
      logic [7:0] v;
      rd(8'hC0, v);
      chk(v, 8'h00);
      wr(8'hC0, 8'hCC);
      wr(8'hC1, 8'h01);
      rd(8'hC0, v);
      chk(v, 8'h00);
      rd(8'hC1, v);
      chk(v, 8'h00);
      wr(8'hC0, 8'h01);
      rd(8'hC0, v);
      chk(v, 8'h01);
      wr(8'hC0, 8'h00);
      rd(8'hC0, v);
      chk(v, 8'h00);
   endtask
   // A START with no STOP leaves the bus busy, so the request waits.
   task t_free();
      int n;
      n = 0;
      b_sda = 0;
      repeat (64) @(negedge SYS_CLK);
      b_scl = 0;
      repeat (64) @(negedge SYS_CLK);
      b_sda = 1;
      wr(8'hC0, 8'h20);
      repeat (64) @(negedge SYS_CLK);
      b_scl = 1;
      for (int c = 0; c < 2000 && SDA_OEN === 1'b1; c++) begin
         @(negedge SYS_CLK);
         if (BIT_CLK_TICK === 1'b1) n++;
      end
      chk({7'h00, n >= 11 && n <= 14}, 8'h01);
   endtask
   // Address and one byte to the peer, then STOP.
   task t_write();
      logic [7:0] v;
      wait_si();
      rd(8'hC0, v);
      chk(v & 8'hE1, 8'hE1);
      TX_DATA = 8'h54;
      wr(8'hC0, 8'h00);
      wait_si();
      rd(8'hC0, v);
      chk(v & 8'hC3, 8'hC3);
      TX_DATA = 8'hA5;
      wr(8'hC0, 8'h00);
      wait_si();
      chk(pbyte, 8'hA5);
      wr(8'hC0, 8'h10);
      for (int c = 0; c < 500 && v[7] !== 1'b0; c++) rd(8'hC0, v);
      chk(v & 8'h91, 8'h00);
      chk({6'h00, scl, sda}, 8'h03);
   endtask
   task hold(input int k);
      repeat (k) @(negedge SYS_CLK);
   endtask
   // Bench as master: START, one byte MSB first, SCL left low.
   task bang(input logic [7:0] a);
      hold(16);
      b_sda = 0;
      for (int i = 7; i >= 0; i--) begin
         hold(8);
         b_scl = 0;
         hold(8);
         b_sda = a[i];
         hold(8);
         b_scl = 1;
      end
      hold(8);
      b_scl = 0;
      hold(16);
   endtask
   // Address 11h: ACK asked before the ACK cycle, answered with NACK;
   // after inhibit, the same address draws neither ACK nor interrupt.
   task t_slave();
      logic [7:0] v;
      bang(8'h22);
      chk(RX_DATA, 8'h22);
      rd(8'hC0, v);
      chk(v, 8'h09);
      b_scl = 1;
      hold(16);
      chk({7'h00, scl}, 8'h00);
      wr(8'hC0, 8'h00);
      hold(16);
      b_scl = 0;
      hold(8);
      b_scl = 1;
      hold(8);
      b_sda = 1;
      slave_inhibit = 1;
      bang(8'h22);
      chk({SDA_OEN, 6'h00, INTERRUPT_PENDING}, 8'h80);
      b_scl = 1;
      hold(8);
      b_sda = 1;
      hold(16);
      rd(8'hC0, v);
      chk(v, 8'h00);
   endtask
   // Disabled, a start request must leave the pins released.
   task t_off();
      en = 0;
      wr(8'hC0, 8'h20);
      repeat (400) @(negedge SYS_CLK);
      chk({6'h00, SCL_OEN, SDA_OEN}, 8'h03);
      // Disable then enable is software's reset; the held START goes out.
      en = 1;
      wait_si();
   endtask
   initial begin
      repeat (16) @(negedge SYS_CLK);
      RESETN = 1;
      t_regs();
      t_free();
      t_write();
      t_slave();
      t_off();
      tally_and_finish();
   end
endmodule
